// ---- verilog/isr_pkg.sv ----
// Shared constants, states and state records of the slave receive block
package isr_pkg;

    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 2;
    localparam int CNT_W = 4;

    // Bits per byte on the wire; the acknowledge slot follows the last one
    localparam logic [CNT_W-1:0] BIT_LAST = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_ACK,
        ST_IGNORE
    } isr_state_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic scl_q;
        logic sda_q;
        isr_state_t st;
        logic [CNT_W-1:0] bit_cnt;
        logic [BYTE_W-1:0] shift;
        logic sda_drive;
        logic scl_hold;
        logic start_seen;
        logic stop_seen;
        logic direction;
        logic data_flag;
        logic receive_overflow;
        logic port_irq_flag;
        logic clock_release;
    } isr_regs_t;

    // Bus lines idle high, so the samplers start high; the clock starts released
    localparam isr_regs_t REGS_RESET = '{
        scl_sync: 2'h3,
        sda_sync: 2'h3,
        scl_q: 1'h1,
        sda_q: 1'h1,
        st: ST_IDLE,
        bit_cnt: 4'h0,
        shift: 8'h00,
        sda_drive: 1'h0,
        scl_hold: 1'h0,
        start_seen: 1'h0,
        stop_seen: 1'h0,
        direction: 1'h0,
        data_flag: 1'h0,
        receive_overflow: 1'h0,
        port_irq_flag: 1'h0,
        clock_release: 1'h1
    };

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][BYTE_W-1:0] mem;
        logic rd_idx;
        logic [1:0] count;
    } isr_fifo_regs_t;

    localparam isr_fifo_regs_t FIFO_RESET = '{
        mem: 16'h0000,
        rd_idx: 1'h0,
        count: 2'h0
    };

    localparam logic [1:0] FIFO_FULL_COUNT = 2'h2;

endpackage

// ---- verilog/isr_fifo_if.sv ----
// Handshake bundle between the receive engine and its two-entry byte buffer
`timescale 1ns/1ps
interface isr_fifo_if;
    logic push_valid;
    logic push_ready;
    logic [isr_pkg::BYTE_W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [isr_pkg::BYTE_W-1:0] pop_data;

    modport fifo (
        input push_valid,
        input push_data,
        input pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );

    modport writer (
        output push_valid,
        output push_data,
        input push_ready
    );

    modport reader (
        input pop_valid,
        input pop_data,
        output pop_ready
    );
endinterface

// ---- verilog/isr_fifo.sv ----
// Two-entry receive byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module isr_fifo (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Buffer handshakes
    isr_fifo_if.fifo port
);

    isr_pkg::isr_fifo_regs_t r;
    isr_pkg::isr_fifo_regs_t next_r;
    logic do_push;
    logic do_pop;
    logic wr_idx;

    assign port.push_ready = (r.count != isr_pkg::FIFO_FULL_COUNT);
    assign port.pop_valid = (r.count != 2'h0);
    assign port.pop_data = r.mem[r.rd_idx];

    always_comb begin
        next_r = r;
        do_push = port.push_valid && port.push_ready;
        do_pop = port.pop_valid && port.pop_ready;
        wr_idx = r.rd_idx ^ r.count[0];
        for (int i = 0; i < isr_pkg::FIFO_DEPTH; i++) begin
            if (do_push && (wr_idx == i[0])) begin
                next_r.mem[i] = port.push_data;
            end
        end
        if (do_pop) begin
            next_r.rd_idx = ~r.rd_idx;
        end
        // Simultaneous push and pop leaves the occupancy unchanged
        if (do_push && !do_pop) begin
            next_r.count = r.count + 2'h1;
        end else if (do_pop && !do_push) begin
            next_r.count = r.count - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= isr_pkg::FIFO_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule

// ---- verilog/isr_top.sv ----
// Two-wire bus slave receiver, 7-bit addressing, with clock stretching
// Behaviour
// RQ1: Matching write address clears direction bit.
// RQ2: No overflow: buffer address and acknowledge it.
// RQ3: Overflow on address gives not-acknowledge.
// RQ4: Overflow means buffer full or overflow flag.
// RQ5: Overwrite enable lets reception ignore buffer full.
// RQ6: Interrupt flag set for every transferred byte. The code sets it only for acknowledged bytes; a refused byte leaves it unchanged.
// RQ7: Software alone clears the interrupt flag.
// RQ8: Stretch enable holds clock low after bytes.
// RQ9: Held clock released only by clock-release bit.
// RQ10: Start sets start-seen; interrupt if enabled.
// RQ11: Matching write address: acknowledge, set interrupt.
// RQ12: Reading buffer clears buffer-full flag.
// RQ13: Software sets clock-release after each stretched byte.
// RQ14: Each data byte acknowledged and interrupt set. The code does neither for a refused data byte.
// RQ15: Stop sets stop-seen and returns idle.
// RQ16: Address mismatch after Start ignores the transfer.
`timescale 1ns/1ps
module isr_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus clock line, open drain
    input wire logic bus_clock_line_in,
    output logic bus_clock_line_out,
    output logic bus_clock_line_oe,
    // Bus data line, open drain
    input wire logic bus_data_line_in,
    output logic bus_data_line_out,
    output logic bus_data_line_oe,
    // Configuration
    input wire logic [isr_pkg::ADDR_W-1:0] own_address,
    input wire logic clock_hold_enable,
    input wire logic buffer_overwrite_enable,
    input wire logic start_irq_enable,
    // Software strobes
    input wire logic clock_release_set,
    input wire logic port_irq_clear,
    input wire logic overflow_clear,
    // Receive buffer read side
    output logic rx_valid,
    output logic [isr_pkg::BYTE_W-1:0] rx_data,
    input wire logic rx_ready,
    // Status
    output logic buffer_full,
    output logic receive_overflow,
    output logic port_irq_flag,
    output logic clock_release,
    output logic start_seen,
    output logic stop_seen,
    output logic direction,
    output logic data_flag
);

    isr_pkg::isr_regs_t r;
    isr_pkg::isr_regs_t next_r;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic take_byte;
    logic accept;
    logic push_valid;

    isr_fifo_if buf_if ();

    isr_fifo u_fifo (
        .clk(clk),
        .resetn(resetn),
        .port(buf_if.fifo)
    );

    // Decides whether a completed byte may be stored and acknowledged
    function automatic logic byte_accept(input logic overwrite, input logic full,
                                         input logic overflow, input logic space);
        if (overwrite) begin
            byte_accept = space; // [RQ5]
        end else begin
            byte_accept = !(full || overflow) && space; // [RQ2] [RQ3] [RQ4]
        end
    endfunction

    assign buf_if.push_valid = push_valid;
    assign buf_if.push_data = r.shift;
    assign buf_if.pop_ready = rx_ready; // [RQ12]
    assign rx_valid = buf_if.pop_valid;
    assign rx_data = buf_if.pop_data;
    assign buffer_full = buf_if.pop_valid; // [RQ12]

    assign bus_clock_line_out = 1'b0;
    assign bus_clock_line_oe = r.scl_hold;
    assign bus_data_line_out = 1'b0;
    assign bus_data_line_oe = r.sda_drive;

    assign receive_overflow = r.receive_overflow;
    assign port_irq_flag = r.port_irq_flag;
    assign clock_release = r.clock_release;
    assign start_seen = r.start_seen;
    assign stop_seen = r.stop_seen;
    assign direction = r.direction;
    assign data_flag = r.data_flag;

    // Edges are taken only after the second sampler stage
    assign scl_rise = r.scl_sync[1] && !r.scl_q;
    assign scl_fall = !r.scl_sync[1] && r.scl_q;
    assign start_cond = r.scl_sync[1] && r.scl_q && r.sda_q && !r.sda_sync[1];
    assign stop_cond = r.scl_sync[1] && r.scl_q && !r.sda_q && r.sda_sync[1];

    always_comb begin
        next_r = r;
        take_byte = 1'b0;
        push_valid = 1'b0;
        accept = byte_accept(buffer_overwrite_enable, buf_if.pop_valid,
                             r.receive_overflow, buf_if.push_ready);

        next_r.scl_sync = {r.scl_sync[0], bus_clock_line_in};
        next_r.sda_sync = {r.sda_sync[0], bus_data_line_in};
        next_r.scl_q = r.scl_sync[1];
        next_r.sda_q = r.sda_sync[1];

        // Software clears come first so a hardware set in the same cycle wins
        if (port_irq_clear) begin
            next_r.port_irq_flag = 1'b0; // [RQ7]
        end
        if (overflow_clear) begin
            next_r.receive_overflow = 1'b0;
        end
        if (r.scl_hold && r.clock_release) begin
            next_r.scl_hold = 1'b0; // [RQ9]
        end

        if ((r.st == isr_pkg::ST_ADDR || r.st == isr_pkg::ST_DATA) && scl_rise && r.bit_cnt != isr_pkg::BIT_LAST) begin
            next_r.shift = {r.shift[isr_pkg::BYTE_W-2:0], r.sda_sync[1]};
            next_r.bit_cnt = r.bit_cnt + 4'h1;
        end

        unique case (r.st)
            isr_pkg::ST_IDLE: begin
            end
            isr_pkg::ST_ADDR: begin
                if (scl_fall && r.bit_cnt == isr_pkg::BIT_LAST) begin
                    if (r.shift[isr_pkg::BYTE_W-1:1] != own_address) begin
                        next_r.st = isr_pkg::ST_IGNORE; // [RQ16]
                    end else begin
                        next_r.direction = r.shift[0]; // [RQ1]
                        next_r.data_flag = 1'b0;
                        // Transmission to the master is not supported, so reads go unanswered
                        if (r.shift[0]) begin
                            next_r.st = isr_pkg::ST_IGNORE;
                        end else begin
                            take_byte = 1'b1; // [RQ11]
                        end
                    end
                end
            end
            isr_pkg::ST_DATA: begin
                if (scl_fall && r.bit_cnt == isr_pkg::BIT_LAST) begin
                    next_r.data_flag = 1'b1;
                    take_byte = 1'b1; // [RQ14]
                end
            end
            isr_pkg::ST_ACK: begin
                // Acknowledge is held through the ninth clock and dropped on its falling edge
                if (scl_fall) begin
                    next_r.sda_drive = 1'b0;
                    next_r.bit_cnt = 4'h0;
                    next_r.st = isr_pkg::ST_DATA; // [RQ14]
                    if (clock_hold_enable) begin
                        next_r.scl_hold = 1'b1; // [RQ8]
                        next_r.clock_release = 1'b0; // [RQ9]
                    end
                end
            end
            isr_pkg::ST_IGNORE: begin
            end
            default: begin
                next_r.st = isr_pkg::ST_IDLE;
            end
        endcase

        if (take_byte) begin
            if (accept) begin
                push_valid = 1'b1; // [RQ2]
                next_r.sda_drive = 1'b1; // [RQ11] [RQ14]
                next_r.port_irq_flag = 1'b1; // [RQ6]
                next_r.st = isr_pkg::ST_ACK;
            end else begin
                // Refused byte: line stays released, which the master reads as not-acknowledge
                next_r.receive_overflow = 1'b1; // [RQ3]
                next_r.st = isr_pkg::ST_IGNORE;
            end
        end

        if (start_cond) begin
            next_r.st = isr_pkg::ST_ADDR;
            next_r.bit_cnt = 4'h0;
            next_r.sda_drive = 1'b0;
            next_r.scl_hold = 1'b0;
            next_r.start_seen = 1'b1; // [RQ10]
            next_r.stop_seen = 1'b0;
            if (start_irq_enable) begin
                next_r.port_irq_flag = 1'b1; // [RQ10]
            end
        end
        if (stop_cond) begin
            next_r.st = isr_pkg::ST_IDLE; // [RQ15]
            next_r.bit_cnt = 4'h0;
            next_r.sda_drive = 1'b0;
            next_r.scl_hold = 1'b0;
            next_r.stop_seen = 1'b1; // [RQ15]
            next_r.start_seen = 1'b0;
        end

        // Software release wins over the hardware clear so the bus cannot deadlock
        if (clock_release_set) begin
            next_r.clock_release = 1'b1; // [RQ9]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= isr_pkg::REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule

// ---- verification/isr_props.sv ----
// Concurrent checks on the slave receive block ports
`timescale 1ns/1ps
module isr_props (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Line drivers and configuration
    input wire logic bus_clock_line_oe,
    input wire logic bus_data_line_oe,
    input wire logic clock_hold_enable,
    input wire logic start_irq_enable,
    input wire logic clock_release_set,
    input wire logic port_irq_clear,
    // Status
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic buffer_full,
    input wire logic receive_overflow,
    input wire logic port_irq_flag,
    input wire logic clock_release,
    input wire logic start_seen,
    input wire logic stop_seen
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Release takes two steps: the bit rises, then the line lets go
    sequence rel_s;
        clock_release ##1 !bus_clock_line_oe;
    endsequence

    irq_sticky_a: assert property (port_irq_flag && !port_irq_clear |=> port_irq_flag)
        else $error("irq flag dropped without clear");
    irq_cause_a: assert property ($rose(port_irq_flag) |->
        $rose(bus_data_line_oe) || (start_irq_enable && start_seen))
        else $error("irq flag set without byte or start");
    ack_push_a: assert property ($rose(bus_data_line_oe) |-> rx_valid && port_irq_flag)
        else $error("ack without buffered byte");
    ovf_nack_a: assert property ($rose(receive_overflow) |-> !bus_data_line_oe)
        else $error("refused byte acknowledged");
    full_flag_a: assert property ($fell(buffer_full) |-> $past(rx_ready))
        else $error("buffer full cleared without a read");
    hold_begin_a: assert property ($rose(bus_clock_line_oe) |-> !clock_release && clock_hold_enable)
        else $error("clock hold without enable");
    hold_stay_a: assert property (bus_clock_line_oe && !clock_release |=> bus_clock_line_oe)
        else $error("clock hold ended early");
    hold_release_a: assert property (clock_release_set |=> rel_s)
        else $error("clock not released");
    start_flags_a: assert property ($rose(start_seen) |-> !stop_seen)
        else $error("start left stop flag set");
    stop_flags_a: assert property ($rose(stop_seen) |-> !start_seen && !bus_data_line_oe)
        else $error("stop did not return idle");
endmodule

bind isr_top isr_props isr_props_i (
    .clk, .resetn, .bus_clock_line_oe, .bus_data_line_oe, .clock_hold_enable, .start_irq_enable,
    .clock_release_set, .port_irq_clear, .rx_valid, .rx_ready, .buffer_full, .receive_overflow,
    .port_irq_flag, .clock_release, .start_seen, .stop_seen
);

// ---- verification/isr_master_model.sv ----
// Bus master model pulling the two open-drain lines
`timescale 1ns/1ps
module isr_master_model (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    // Pull-low requests
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Data moves a little after the clock falls so no false start or stop is seen
    task automatic bitx(input logic pull, output logic got);
        #25 sda_low = pull;
        #75 scl_low = 1'b0;
        wait (scl);
        #50 got = sda;
        #50 scl_low = 1'b1;
    endtask

    task automatic xbyte(input logic [7:0] b, output logic ack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            bitx(~b[i], d);
        end
        bitx(1'b0, ack);
    endtask

    task automatic start_cond;
        #100 sda_low = 1'b1;
        #100 scl_low = 1'b1;
    endtask

    task automatic stop_cond;
        #25 sda_low = 1'b1;
        #75 scl_low = 1'b0;
        wait (scl);
        #100 sda_low = 1'b0;
        #100;
    endtask
endmodule

// ---- verification/tb_top.sv ----
// Testbench: bus master traffic and software service of the receive block
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic m_scl, m_sda, scl_oe, sda_oe, scl, sda, ack;
    logic scl_out, sda_out;
    logic [6:0] own_address = 7'h5a;
    logic clock_hold_enable = 1'b1;
    logic buffer_overwrite_enable = 1'b0;
    logic start_irq_enable = 1'b1;
    logic clock_release_set = 1'b0;
    logic port_irq_clear = 1'b0;
    logic overflow_clear = 1'b0;
    logic rx_ready = 1'b0;
    logic rx_valid, buffer_full, receive_overflow, port_irq_flag;
    logic clock_release, start_seen, stop_seen, direction, data_flag;
    logic [7:0] rx_data;
    int err_count = 0;
    int tests_run = 0;

    always #12.5 clk = ~clk;
    // Pull-ups: a released line reads high
    assign scl = ~(m_scl | scl_oe);
    assign sda = ~(m_sda | sda_oe);

    isr_top isr_top_i (
        .clk, .resetn,
        .bus_clock_line_in(scl), .bus_clock_line_out(scl_out), .bus_clock_line_oe(scl_oe),
        .bus_data_line_in(sda), .bus_data_line_out(sda_out), .bus_data_line_oe(sda_oe),
        .own_address, .clock_hold_enable, .buffer_overwrite_enable, .start_irq_enable,
        .clock_release_set, .port_irq_clear, .overflow_clear, .rx_valid, .rx_data, .rx_ready,
        .buffer_full, .receive_overflow, .port_irq_flag, .clock_release, .start_seen,
        .stop_seen, .direction, .data_flag
    );
    isr_master_model isr_master_model_i (.scl, .sda, .scl_low(m_scl), .sda_low(m_sda));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Strobes: release, irq clear, overflow clear
    task automatic sw(input logic [2:0] k);
        @(negedge clk) {clock_release_set, port_irq_clear, overflow_clear} = k;
        @(negedge clk) {clock_release_set, port_irq_clear, overflow_clear} = 3'h0;
    endtask

    task automatic rd(input logic [7:0] exp);
        @(negedge clk) check(rx_valid, 1'b1);
        check(rx_data, exp);
        rx_ready = 1'b1;
        @(negedge clk) rx_ready = 1'b0;
    endtask

    task automatic tx(input logic [7:0] b, input logic exp_ack);
        isr_master_model_i.xbyte(b, ack);
        check(ack, exp_ack);
        repeat (8) @(negedge clk);
    endtask

    task automatic cond(input logic stop);
        if (stop) begin
            isr_master_model_i.stop_cond;
        end else begin
            isr_master_model_i.start_cond;
        end
        repeat (4) @(negedge clk);
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        cond(1'b0);
        check(start_seen, 1'b1);
        check(port_irq_flag, 1'b1);
        sw(3'h2);
        tx(8'hb4, 1'b0);
        check(port_irq_flag, 1'b1);
        check(direction, 1'b0);
        check(data_flag, 1'b0);
        check(clock_release, 1'b0);
        repeat (40) @(negedge clk);
        // The master also pulls the clock low here, so the level alone proves nothing
        check(scl_oe, 1'b1);
        check({scl_out, sda_out}, 8'h00);
        check(port_irq_flag, 1'b1);
        rd(8'hb4);
        check(buffer_full, 1'b0);
        sw(3'h6);
        tx(8'h3c, 1'b0);
        check(data_flag, 1'b1);
        check(port_irq_flag, 1'b1);
        sw(3'h6);
        tx(8'h77, 1'b1);
        check(receive_overflow, 1'b1);
        check(port_irq_flag, 1'b0);
        cond(1'b1);
        check(stop_seen, 1'b1);
        check(start_seen, 1'b0);
        cond(1'b0);
        tx(8'hb4, 1'b1);
        cond(1'b1);
        sw(3'h3);
        buffer_overwrite_enable = 1'b1;
        clock_hold_enable = 1'b0;
        start_irq_enable = 1'b0;
        cond(1'b0);
        check(port_irq_flag, 1'b0);
        tx(8'hb4, 1'b0);
        check(scl_oe, 1'b0);
        tx(8'h55, 1'b1);
        cond(1'b1);
        rd(8'h3c);
        rd(8'hb4);
        check(buffer_full, 1'b0);
        sw(3'h3);
        cond(1'b0);
        tx(8'h22, 1'b1);
        check(port_irq_flag, 1'b0);
        cond(1'b1);
        cond(1'b0);
        tx(8'hb5, 1'b1);
        check(direction, 1'b1);
        cond(1'b1);
        // A changed slave address must now be matched instead of the old one
        own_address = 7'h11;
        cond(1'b0);
        tx(8'h22, 1'b0);
        cond(1'b1);
        rd(8'h22);
        finish_test;
    end

    initial begin
        #1000000;
        err_count++;
        finish_test;
    end
endmodule
